// ==== design/swc_regs.svh ====
/*
 Register offsets, field positions, reset values and timing counts of the
 sleep and wake-up controller. It assumes a byte-addressed Avalon-MM slave
 with one 32-bit word per register.
*/
`ifndef SWC_REGS_SVH
`define SWC_REGS_SVH

`define SWC_CTRL_OFS 5'h00
`define SWC_STAT_OFS 5'h04
`define SWC_IRQ_STAT_OFS 5'h08
`define SWC_IRQ_EN_OFS 5'h0C
`define SWC_IRQ_CLR_OFS 5'h10

`define SWC_CTRL_OSC_LSB 0
`define SWC_CTRL_OSC_MSB 2
`define SWC_CTRL_CLK_OUT_BIT 3
`define SWC_CTRL_RST 4'h4

`define SWC_OSC_LOW_POWER 3'h0
`define SWC_OSC_STD_XTAL 3'h1
`define SWC_OSC_FAST_XTAL 3'h2
`define SWC_OSC_INT_RC 3'h4
`define SWC_OSC_EXT_RC 3'h5

`define SWC_STAT_TIMEOUT_BIT 0
`define SWC_STAT_PWRDN_BIT 1
`define SWC_STAT_SLEEP_BIT 2
`define SWC_STAT_CLK_OUT_BIT 3

`define SWC_EV_SLEEP 0
`define SWC_EV_NOP 1
`define SWC_EV_WAKE 2
`define SWC_EV_WATCHDOG 3
`define SWC_EV_NUM 4

`define SWC_OST_TOSC 1024
`define SWC_DUMMY_CYCLES 2
`define SWC_VECTOR_ADDR 13'h0004

`endif

// ==== design/swc_pkg.sv ====
/*
 Types of the sleep and wake-up controller: core request and response
 bundles and the controller states. Assumes swc_regs.svh for constants.
*/
package swc_pkg;

   typedef enum logic [2:0] {
      ST_RUN,
      ST_SLEEP,
      ST_OST,
      ST_NEXT,
      ST_DUMMY
   } swc_state_e;

   // From the processor core and watchdog
   typedef struct packed {
      logic sleep_exec;
      logic insn_strobe;
      logic global_interrupt_enable;
      logic watchdog_timeout;
   } swc_core_req_s;

   // Back to the processor core, watchdog and clock system
   typedef struct packed {
      logic stall;
      logic osc_run;
      logic watchdog_clr;
      logic resume;
      logic vector_branch;
      logic [12:0] vector_addr;
      logic dummy_cycle;
   } swc_core_resp_s;

endpackage

// ==== design/swc_ost.sv ====
/*
 Oscillator start-up delay counter. A start pulse arms it; done pulses once
 after the programmed number of clock cycles. Assumes sys_clk is the
 oscillator being started.
*/
`timescale 1ns/1ps
`default_nettype none
module swc_ost #(
   parameter int CYCLES = 1024
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic start,
   output logic busy,
   output logic done
);
   localparam int W = $clog2(CYCLES + 1);

   logic [W-1:0] cnt_r;
   logic busy_r;
   logic done_r;

   if (CYCLES < 1) begin : g_chk
      $error("swc_ost: CYCLES must be at least 1");
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cnt_r <= '0;
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         done_r <= 1'b0;
         if (start) begin
            cnt_r <= W'(CYCLES - 1);
            busy_r <= 1'b1;
         end else if (busy_r) begin
            if (cnt_r == '0) begin
               busy_r <= 1'b0;
               done_r <= 1'b1;
            end else begin
               cnt_r <= cnt_r - W'(1);
            end
         end
      end
   end

   assign busy = busy_r;
   assign done = done_r;
endmodule
`default_nettype wire

// ==== design/swc_top.sv ====
/*
 Sleep and wake-up controller: decides the fate of a power-down
 instruction, keeps the time-out and power-down flags, times oscillator
 start-up and steers the core back in line or to the interrupt vector.
 Assumes a core giving one sleep_exec pulse as the power-down instruction
 completes and one insn_strobe per executed instruction cycle, and an
 Avalon-MM master for the registers.
*/
`timescale 1ns/1ps
`default_nettype none
`include "swc_regs.svh"
module swc_top #(
   parameter int N_SRC = 4,
   parameter int OST_CYCLES = `SWC_OST_TOSC,
   parameter int DUMMY_CYCLES = `SWC_DUMMY_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire swc_pkg::swc_core_req_s core_req,
   input wire logic [N_SRC-1:0] int_enable,
   input wire logic [N_SRC-1:0] int_flag,
   output swc_pkg::swc_core_resp_s core_resp,
   output logic timeout_flag,
   output logic powerdown_flag,
   output logic clock_output_pin_en,
   output logic irq
);
   import swc_pkg::*;

   localparam int DW = $clog2(DUMMY_CYCLES + 1);

   if (N_SRC < 1 || DUMMY_CYCLES < 1 || OST_CYCLES < 1) begin : g_chk
      $error("swc_top: N_SRC, DUMMY_CYCLES and OST_CYCLES must be at least 1");
   end

   // Only the three crystal modes need the start-up wait
   function automatic logic is_crystal(input logic [2:0] mode);
      case (mode)
         `SWC_OSC_LOW_POWER: is_crystal = 1'b1;
         `SWC_OSC_STD_XTAL: is_crystal = 1'b1;
         `SWC_OSC_FAST_XTAL: is_crystal = 1'b1;
         default: is_crystal = 1'b0;
      endcase
   endfunction

   function automatic logic reg_hit(input logic [4:0] addr, input logic [4:0] ofs);
      reg_hit = (addr == ofs);
   endfunction

   swc_state_e state_r;
   swc_state_e state_nxt;
   logic [DW-1:0] dummy_cnt_r;
   logic [DW-1:0] dummy_cnt_nxt;
   logic wake;
   logic wake_before_r;
   logic int_wake_r;
   logic go_wake;
   logic resume_now;
   logic wake_by_int;
   logic full_sleep;
   logic nop_sleep;
   logic ost_start;
   logic ost_done;
   logic resume_r;
   logic branch_nxt;
   logic branch_r;
   logic watchdog_clr_r;
   logic timeout_r;
   logic pwrdn_r;
   logic [3:0] ctrl_r;
   logic [`SWC_EV_NUM-1:0] irq_stat_r;
   logic [`SWC_EV_NUM-1:0] irq_en_r;
   logic [`SWC_EV_NUM-1:0] ev;
   logic ack_r;
   logic [31:0] rdata_r;
   logic [31:0] rd_word;
   logic [2:0] osc_mode;
   logic wr_en;

   assign osc_mode = ctrl_r[`SWC_CTRL_OSC_MSB:`SWC_CTRL_OSC_LSB];

   // Global enable deliberately left out of the wake term
   assign wake = |(int_enable & int_flag);

   // Pending one cycle earlier counts as before the instruction
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wake_before_r <= 1'b0;
      end else begin
         wake_before_r <= wake;
      end
   end

   swc_ost #(
      .CYCLES(OST_CYCLES)
   ) u_ost (
      .sys_clk(sys_clk),
      .rst(rst),
      .start(ost_start),
      .busy(),
      .done(ost_done)
   );

   assign wake_by_int = go_wake ? wake : int_wake_r;

   always_comb begin
      state_nxt = state_r;
      dummy_cnt_nxt = dummy_cnt_r;
      go_wake = 1'b0;
      resume_now = 1'b0;
      full_sleep = 1'b0;
      nop_sleep = 1'b0;
      ost_start = 1'b0;
      branch_nxt = 1'b0;
      case (state_r)
         ST_RUN: begin
            if (core_req.sleep_exec) begin
               if (wake_before_r) begin
                  nop_sleep = 1'b1;
               end else begin
                  full_sleep = 1'b1;
                  // Arising during the instruction: out right after it
                  if (wake || core_req.watchdog_timeout) begin
                     go_wake = 1'b1;
                  end else begin
                     state_nxt = ST_SLEEP;
                  end
               end
            end
         end
         ST_SLEEP: begin
            if (wake || core_req.watchdog_timeout) begin
               go_wake = 1'b1;
            end
         end
         ST_OST: begin
            if (ost_done) begin
               resume_now = 1'b1;
            end
         end
         ST_NEXT: begin
            // Prefetched instruction runs before the vector
            if (core_req.insn_strobe) begin
               dummy_cnt_nxt = '0;
               state_nxt = ST_DUMMY;
            end
         end
         ST_DUMMY: begin
            if (core_req.insn_strobe) begin
               if (dummy_cnt_r == DW'(DUMMY_CYCLES - 1)) begin
                  branch_nxt = 1'b1;
                  state_nxt = ST_RUN;
               end else begin
                  dummy_cnt_nxt = dummy_cnt_r + DW'(1);
               end
            end
         end
         default: begin
            state_nxt = ST_RUN;
         end
      endcase
      if (go_wake) begin
         if (is_crystal(osc_mode)) begin
            ost_start = 1'b1;
            state_nxt = ST_OST;
         end else begin
            resume_now = 1'b1;
         end
      end
      if (resume_now) begin
         // Watchdog wake never vectors; interrupt wake follows global enable
         if (wake_by_int && core_req.global_interrupt_enable) begin
            state_nxt = ST_NEXT;
         end else begin
            state_nxt = ST_RUN;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_r <= ST_RUN;
         dummy_cnt_r <= '0;
      end else begin
         state_r <= state_nxt;
         dummy_cnt_r <= dummy_cnt_nxt;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         int_wake_r <= 1'b0;
      end else if (go_wake) begin
         int_wake_r <= wake;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         resume_r <= 1'b0;
      end else begin
         resume_r <= resume_now;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         branch_r <= 1'b0;
      end else begin
         branch_r <= branch_nxt;
      end
   end

   // One-cycle clear to the watchdog and its postscaler
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         watchdog_clr_r <= 1'b0;
      end else begin
         watchdog_clr_r <= full_sleep;
      end
   end

   // Time-out in the same cycle as a power-down wins
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         timeout_r <= 1'b1;
      end else if (core_req.watchdog_timeout) begin
         timeout_r <= 1'b0;
      end else if (full_sleep) begin
         timeout_r <= 1'b1;
      end
   end

   // Comes up set, as after power-up; a no-op power-down leaves it unchanged
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pwrdn_r <= 1'b1;
      end else if (full_sleep) begin
         pwrdn_r <= 1'b0;
      end
   end

   assign timeout_flag = timeout_r;
   assign powerdown_flag = pwrdn_r;

   // Crystal modes own the oscillator pins
   assign clock_output_pin_en = ctrl_r[`SWC_CTRL_CLK_OUT_BIT] &&
      !is_crystal(osc_mode);

   assign core_resp.stall = (state_r == ST_SLEEP) || (state_r == ST_OST);
   assign core_resp.osc_run = (state_r != ST_SLEEP);
   assign core_resp.watchdog_clr = watchdog_clr_r;
   assign core_resp.resume = resume_r;
   assign core_resp.vector_branch = branch_r;
   assign core_resp.vector_addr = `SWC_VECTOR_ADDR;
   assign core_resp.dummy_cycle = (state_r == ST_DUMMY) && core_req.insn_strobe;

   always_comb begin
      ev = '0;
      ev[`SWC_EV_SLEEP] = full_sleep;
      ev[`SWC_EV_NOP] = nop_sleep;
      ev[`SWC_EV_WAKE] = resume_now;
      ev[`SWC_EV_WATCHDOG] = core_req.watchdog_timeout;
   end

   // One wait state per access; the answer edge is the one with ack_r high
   assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
   assign wr_en = avs_write && ack_r;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= (avs_read || avs_write) && !ack_r;
      end
   end

   // Word assembled first so the registered path sees one mux
   always_comb begin
      rd_word = 32'h0000_0000;
      case (avs_address)
         `SWC_CTRL_OFS: rd_word[3:0] = ctrl_r;
         `SWC_STAT_OFS: begin
            rd_word[`SWC_STAT_TIMEOUT_BIT] = timeout_r;
            rd_word[`SWC_STAT_PWRDN_BIT] = pwrdn_r;
            rd_word[`SWC_STAT_SLEEP_BIT] = core_resp.stall;
            rd_word[`SWC_STAT_CLK_OUT_BIT] = clock_output_pin_en;
         end
         `SWC_IRQ_STAT_OFS: rd_word[`SWC_EV_NUM-1:0] = irq_stat_r;
         `SWC_IRQ_EN_OFS: rd_word[`SWC_EV_NUM-1:0] = irq_en_r;
         default: rd_word = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rdata_r <= 32'h0000_0000;
      end else if (avs_read && !ack_r) begin
         rdata_r <= rd_word;
      end
   end

   assign avs_readdata = rdata_r;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ctrl_r <= `SWC_CTRL_RST;
      end else if (wr_en && reg_hit(avs_address, `SWC_CTRL_OFS)) begin
         ctrl_r <= avs_writedata[3:0];
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         irq_en_r <= '0;
      end else if (wr_en && reg_hit(avs_address, `SWC_IRQ_EN_OFS)) begin
         irq_en_r <= avs_writedata[`SWC_EV_NUM-1:0];
      end
   end

   // A new event beats a clear in the same cycle
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         irq_stat_r <= '0;
      end else if (wr_en && reg_hit(avs_address, `SWC_IRQ_CLR_OFS)) begin
         irq_stat_r <= (irq_stat_r & ~avs_writedata[`SWC_EV_NUM-1:0]) | ev;
      end else begin
         irq_stat_r <= irq_stat_r | ev;
      end
   end

   assign irq = |(irq_stat_r & irq_en_r);
endmodule
`default_nettype wire

// ==== dv/swc_chk.sv ====
/*
 Port checker of swc_top.
 Assumes it is bound onto swc_top and that swc_pkg is compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module swc_chk #(
   parameter int N_SRC = 4,
   parameter int OST_CYCLES = 1024,
   parameter int DUMMY_CYCLES = 2
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire swc_pkg::swc_core_req_s core_req,
   input wire logic [N_SRC-1:0] int_enable,
   input wire logic [N_SRC-1:0] int_flag,
   input wire swc_pkg::swc_core_resp_s core_resp,
   input wire logic timeout_flag,
   input wire logic powerdown_flag
);
   import swc_pkg::*;
   // Start-up delay plus decision and pulse slack
   localparam int WMAX = OST_CYCLES + 8;
   logic wake;
   logic [3:0] dcnt_r;
   assign wake = |(int_enable & int_flag);
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         dcnt_r <= 4'h0;
      end else if (core_resp.resume) begin
         dcnt_r <= 4'h0;
      end else if (core_resp.dummy_cycle) begin
         dcnt_r <= dcnt_r + 4'h1;
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   sequence s_wait;
      avs_waitrequest ##1 !avs_waitrequest;
   endsequence
   sequence s_sleep;
      core_req.sleep_exec && !core_resp.stall;
   endsequence
   property p_wait;
      $rose(avs_read || avs_write) |-> s_wait;
   endproperty
   property p_nop;
      s_sleep ##0 $past(wake) |=> $stable(powerdown_flag) && !core_resp.watchdog_clr;
   endproperty
   property p_full;
      s_sleep ##0 (!$past(wake) && !core_req.watchdog_timeout)
         |=> core_resp.watchdog_clr && !powerdown_flag && timeout_flag;
   endproperty
   property p_wdt;
      core_req.watchdog_timeout |=> !timeout_flag;
   endproperty
   property p_dum;
      core_resp.vector_branch |-> dcnt_r == DUMMY_CYCLES && core_resp.vector_addr == 13'h0004;
   endproperty
   property p_fell;
      $fell(core_resp.stall) |-> core_resp.resume;
   endproperty
   property p_wake;
      core_resp.stall && wake |-> ##[1:WMAX] !core_resp.stall;
   endproperty
   property p_osc;
      !core_resp.osc_run |-> core_resp.stall;
   endproperty
   a_wait: assert property (p_wait) else $error("bus wait state wrong");
   a_nop: assert property (p_nop) else $error("no-op sleep changed state");
   a_full: assert property (p_full) else $error("full sleep effects missing");
   a_wdt: assert property (p_wdt) else $error("time-out flag not cleared");
   a_dum: assert property (p_dum) else $error("vector branch wrong");
   a_fell: assert property (p_fell) else $error("stall ended without resume");
   a_wake: assert property (p_wake) else $error("wake not honoured");
   a_osc: assert property (p_osc) else $error("oscillator off while running");
endmodule
`default_nettype wire

// ==== dv/swc_core_model.sv ====
/*
 Processor core model: one instruction per running cycle, power-down on request.
 Assumes the bench pulses sleep_go and drives glob_en and wdog_to.
*/
`timescale 1ns/1ps
`default_nettype none
module swc_core_model (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic sleep_go,
   input wire logic glob_en,
   input wire logic wdog_to,
   input wire swc_pkg::swc_core_resp_s core_resp,
   output var swc_pkg::swc_core_req_s core_req
);
   import swc_pkg::*;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         core_req <= '0;
      end else begin
         core_req.sleep_exec <= sleep_go;
         // Next instruction runs first after wake
         core_req.insn_strobe <= !core_resp.stall;
         core_req.global_interrupt_enable <= glob_en;
         core_req.watchdog_timeout <= wdog_to;
      end
   end
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
/*
 Self-checking bench of swc_top with core model and bound checker.
 Assumes swc_pkg and swc_regs.svh are visible to the compiler.
*/
`timescale 1ns/1ps
`default_nettype none
`include "swc_regs.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module testbench;
   import swc_pkg::*;
   localparam int OST = 8;
   logic sys_clk = 0, rst = 1, avs_read = 0, avs_write = 0, avs_waitrequest;
   logic [4:0] avs_address = 0;
   logic [31:0] avs_writedata = 0, avs_readdata, exp_d;
   logic sleep_go = 0, glob_en = 0, wdog_to = 0, timeout_flag, powerdown_flag, irq;
   logic clock_output_pin_en;
   logic [3:0] int_enable = 0, int_flag = 0;
   logic [2:0] md[5] = '{`SWC_OSC_LOW_POWER, `SWC_OSC_STD_XTAL, `SWC_OSC_FAST_XTAL,
      `SWC_OSC_INT_RC, `SWC_OSC_EXT_RC};
   logic [2:0] cm[3] = '{`SWC_OSC_INT_RC, `SWC_OSC_STD_XTAL, `SWC_OSC_FAST_XTAL};
   swc_core_req_s core_req;
   swc_core_resp_s core_resp;
   logic [31:0] q_rd[$];
   int n_mismatch = 0, checks = 0, n_vec = 0, dcnt = 0, lat, b;
   int unsigned r;
   initial forever #2.5 sys_clk = !sys_clk;
   swc_top #(.OST_CYCLES(OST)) swc_top_i (.sys_clk, .rst, .avs_address, .avs_read,
      .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .core_req, .int_enable,
      .int_flag, .core_resp, .timeout_flag, .powerdown_flag, .clock_output_pin_en, .irq);
   swc_core_model swc_core_model_i (.sys_clk, .rst, .sleep_go, .glob_en, .wdog_to, .core_resp,
      .core_req);
   task stop_test;
      if (n_mismatch == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Reads note d as the expected word
   task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      if (!w) q_rd.push_back(d);
      @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
      avs_read <= 0;
      avs_write <= 0;
      @(posedge sys_clk);
   endtask
   task sleep;
      // Software has cleared the watchdog: no time-out pending
      wdog_to <= 0;
      sleep_go <= 1;
      @(posedge sys_clk);
      sleep_go <= 0;
      repeat (4) @(posedge sys_clk);
   endtask
   always @(posedge sys_clk) begin
      if (avs_read && avs_waitrequest === 1'b0) begin
         exp_d = q_rd.pop_front();
         `CHK("rdata", exp_d, avs_readdata)
      end
      if (core_resp.resume === 1'b1) dcnt = 0;
      if (core_resp.dummy_cycle === 1'b1) dcnt++;
      if (core_resp.vector_branch === 1'b1) begin
         n_vec++;
         `CHK("dummy", 2, dcnt)
         `CHK("vector", 13'h0004, core_resp.vector_addr)
      end
   end
   initial begin
      void'($urandom(19880));
      repeat (5) @(posedge sys_clk);
      rst <= 0;
      @(posedge sys_clk);
      bus(0, `SWC_CTRL_OFS, 32'h4);
      bus(0, `SWC_STAT_OFS, 32'h3);
      bus(0, 5'h14, 32'h0);
      foreach (md[i]) begin
         bus(1, `SWC_CTRL_OFS, {28'h0, 1'b1, md[i]});
         bus(0, `SWC_STAT_OFS, {28'h0, md[i][2], 3'h3});
         `CHK("clock_output_pin", md[i][2], clock_output_pin_en)
      end
      bus(1, `SWC_CTRL_OFS, 32'h4);
      b = $urandom % 4;
      r = $urandom;
      int_enable <= r[3:0] | (4'h1 << b);
      int_flag <= 4'h1 << b;
      repeat (3) @(posedge sys_clk);
      sleep();
      bus(0, `SWC_STAT_OFS, 32'h3);
      int_flag <= 0;
      for (int k = 0; k < 3; k++) begin
         bus(1, `SWC_CTRL_OFS, {29'h0, cm[k]});
         glob_en <= (k > 0);
         sleep();
         bus(0, `SWC_STAT_OFS, 32'h5);
         if (k == 2) wdog_to <= 1;
         else int_flag <= 4'h1 << b;
         lat = 0;
         do begin
            @(posedge sys_clk);
            wdog_to <= 0;
            lat++;
         end while (core_resp.resume !== 1'b1);
         `CHK("latency", 1'b1, k == 0 ? lat < 6 : (lat > OST && lat < OST + 10))
         int_flag <= 0;
         repeat (8) @(posedge sys_clk);
         bus(0, `SWC_STAT_OFS, k == 2 ? 32'h0 : 32'h1);
      end
      `CHK("vectors", 1, n_vec)
      r = $urandom % 15 + 1;
      bus(0, `SWC_IRQ_STAT_OFS, 32'hF);
      bus(1, `SWC_IRQ_EN_OFS, 32'h0);
      `CHK("irq masked", 1'b0, irq)
      bus(1, `SWC_IRQ_EN_OFS, r);
      bus(0, `SWC_IRQ_EN_OFS, r);
      `CHK("irq", 1'b1, irq)
      bus(1, `SWC_IRQ_CLR_OFS, 32'hF);
      bus(0, `SWC_IRQ_STAT_OFS, 32'h0);
      `CHK("irq cleared", 1'b0, irq)
      stop_test();
   end
   // Whole run is under two hundred cycles
   initial begin
      repeat (3000) @(posedge sys_clk);
      n_mismatch++;
      stop_test();
   end
endmodule
bind swc_top swc_chk #(.N_SRC(N_SRC), .OST_CYCLES(OST_CYCLES), .DUMMY_CYCLES(DUMMY_CYCLES))
   swc_chk_i (.sys_clk, .rst, .avs_read, .avs_write, .avs_waitrequest, .core_req,
   .int_enable, .int_flag, .core_resp, .timeout_flag, .powerdown_flag);
`default_nettype wire
